//--- design/ddr3_pin_consts.svh
`ifndef DDR3_PIN_CONSTS_SVH
`define DDR3_PIN_CONSTS_SVH

// ----------------------------------------------------------------------
// Command codes {rasN, casN, weN}
// ----------------------------------------------------------------------
`define CMD_MRS        3'h0
`define CMD_REFRESH    3'h1
`define CMD_PRECHARGE  3'h2
`define CMD_ACTIVATE   3'h3
`define CMD_WRITE      3'h4
`define CMD_READ       3'h5
`define CMD_ZQCAL      3'h6
`define CMD_NOP        3'h7

// ----------------------------------------------------------------------
// Address field positions
// ----------------------------------------------------------------------
`define ADDR_AUTOPRE   10
`define ADDR_CHOP      12
`define MR1_TDQS_BIT   11
`define ROW_BITS       13
`define COL_BITS       10

// ----------------------------------------------------------------------
// Burst and bank figures
// ----------------------------------------------------------------------
`define BANKS          8
`define BEATS_FULL     4'h8
`define BEATS_CHOP     4'h4

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_MR         16'h0000

`endif

//--- design/ddr3_pin_pkg.sv
package ddr3_pin_pkg;

   typedef enum logic [1:0]
   {
      PWR_ACTIVE   = 2'h0,
      PWR_DOWN_PRE = 2'h1,
      PWR_DOWN_ACT = 2'h3,
      PWR_SELF_REF = 2'h2
   } pwr_state_t;

   typedef enum logic [1:0]
   {
      BURST_IDLE  = 2'h0,
      BURST_WRITE = 2'h1,
      BURST_READ  = 2'h3
   } burst_state_t;

endpackage : ddr3_pin_pkg

//--- design/ddr3_pin_command_interface.sv
// Behaviour
// - Address and control are captured on the rising edge of the pin clock.
// - CKE high runs the clock input and input buffers; low stops the buffers, and stops the clock input in self-refresh only.
// - CKE low enters precharge power-down, self-refresh or active power-down.
// - A rise of CKE leaves self-refresh without needing a clock edge.
// - Power-down keeps only the clock, ODT and CKE inputs alive.
// - Self-refresh keeps only the CKE input alive.
// - With chip select high the command lines are ignored.
// - The command comes from RAS, CAS and WE with chip select together.
// - Registered ODT with termination configured terminates all x16 data pins.
// - With termination disabled in both mode registers ODT is ignored.
// - MR1 bit 11 picks mask or termination strobe on x8 parts.
// - Write bytes whose mask sample is high are disabled; a beat with both mask samples high is discarded.
// - Bank pins pick the bank, or the mode register for a set command.
// - Address pins give row, column or op-code by command.
// - A10 high on the last read or write precharges the bank in cmdBank once the burst ends, unless a command is taken in that cycle.
// - A10 high on precharge closes all banks; low closes the selected one.
// - A12 low chops the burst; high gives a full burst.
// - RESET low resets the device at once; controller keeps it high.
// - Bursts are eight beats, or four when chopped.
`timescale 1ns/1ps
`default_nettype none
`include "ddr3_pin_consts.svh"

module ddr3_pin_command_interface
(
   // System
   input  wire logic                          clk_sys,
   input  wire logic                          rstn,
   // Pin clock and control
   input  wire logic                          memClk,
   input  wire logic                          clkEn,
   input  wire logic                          chipSelN,
   input  wire logic                          rasN,
   input  wire logic                          casN,
   input  wire logic                          weN,
   input  wire logic                          odt,
   input  wire logic [2:0]                    bankAddr,
   input  wire logic [15:0]                   addr,
   // Data strobe and mask
   input  wire logic                          dataStrobe,
   input  wire logic [1:0]                    dataMask,
   input  wire logic [15:0]                   dqIn,
   // Status
   output var  ddr3_pin_pkg::pwr_state_t      pwrState,
   output var  ddr3_pin_pkg::burst_state_t    burstState,
   output logic                               buffersOn,
   output logic                               clkInputOn,
   output logic                               termOn,
   output logic                               tdqsOn,
   output logic [7:0]                         openBanks,
   output logic [2:0]                         cmdBank,
   output logic [15:0]                        cmdAddr,
   output logic [2:0]                         cmdCode,
   output logic                               cmdValid,
   output logic                               autoPrecharge,
   output logic [3:0]                         burstBeats,
   output logic [15:0]                        wrData,
   output logic [1:0]                         wrByteEn,
   output logic                               wrValid,
   output logic [15:0]                        modeReg1,
   output logic [15:0]                        modeReg2
);
   import ddr3_pin_pkg::*;
   default clocking dcb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);

   // ----------------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------------
   // Every pin passes two flops; a slow pin clock keeps its edges visible.
   localparam int SW = 45;
   logic [SW-1:0] syncA;
   logic [SW-1:0] syncB;
   logic          clkPrev;
   logic          strobePrev;
   logic          ceLast;

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         syncA <= '0;
         syncB <= '0;
      end
      else
      begin
         syncA <= {memClk, clkEn, chipSelN, rasN, casN, weN, odt, bankAddr,
                   addr, dataStrobe, dataMask, dqIn[15:0]};
         syncB <= syncA;
      end
   end

   wire logic        sClk    = syncB[44];
   wire logic        sCe     = syncB[43];
   wire logic        sCs     = syncB[42];
   wire logic [2:0]  sCmd    = syncB[41:39];
   wire logic        sOdt    = syncB[38];
   wire logic [2:0]  sBank   = syncB[37:35];
   wire logic [15:0] sAddr   = syncB[34:19];
   wire logic        sStrobe = syncB[18];
   wire logic [1:0]  sMask   = syncB[17:16];
   wire logic [15:0] sDq     = syncB[15:0];
   wire logic        clkRise = sClk && !clkPrev && clkInputOn;

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         clkPrev    <= 1'b0;
         strobePrev <= 1'b0;
         ceLast     <= 1'b1;
      end
      else
      begin
         clkPrev    <= sClk;
         strobePrev <= sStrobe;
         if (clkRise || pwrState == PWR_SELF_REF)
            ceLast  <= sCe;
      end
   end

   wire logic strobeEdge = (sStrobe != strobePrev) && buffersOn;

   function automatic logic [3:0] beats_for(input logic fullBurst);
      beats_for = fullBurst ? `BEATS_FULL : `BEATS_CHOP;
   endfunction : beats_for

   // ----------------------------------------------------------------------
   // Command decode
   // ----------------------------------------------------------------------
   // chip select masks the code; reset blocks every command.
   wire logic cmdTaken = clkRise && !sCs && pwrState == PWR_ACTIVE
                         && sCe;

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         cmdValid      <= 1'b0;
         cmdCode       <= `CMD_NOP;
         cmdBank       <= 3'h0;
         cmdAddr       <= 16'h0000;
         autoPrecharge <= 1'b0;
      end
      else
      begin
         cmdValid <= cmdTaken && sCmd != `CMD_NOP;
         if (cmdTaken)
         begin
            cmdCode <= sCmd;
            cmdBank <= sBank;
            if (sCmd == `CMD_ACTIVATE)
               cmdAddr <= {3'h0, sAddr[`ROW_BITS-1:0]};
            else if (sCmd == `CMD_READ || sCmd == `CMD_WRITE)
               cmdAddr <= {6'h00, sAddr[`COL_BITS-1:0]};
            else
               cmdAddr <= sAddr;
            autoPrecharge <= (sCmd == `CMD_READ || sCmd == `CMD_WRITE)
                             && sAddr[`ADDR_AUTOPRE];
         end
      end
   end

   // ----------------------------------------------------------------------
   // Mode registers
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         modeReg1 <= `RST_MR;
         modeReg2 <= `RST_MR;
      end
      else if (cmdTaken && sCmd == `CMD_MRS)
         if (sBank == 3'h1)
            modeReg1 <= sAddr;
         else if (sBank == 3'h2)
            modeReg2 <= sAddr;
   end

   // a controller keeps bit 11 low on this part, so this stays low.
   assign tdqsOn = modeReg1[`MR1_TDQS_BIT];

   // ----------------------------------------------------------------------
   // Bank state
   // ----------------------------------------------------------------------
   logic pendClose;
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         openBanks <= 8'h00;
      else if (cmdTaken)
      begin
         case (sCmd)
            `CMD_ACTIVATE:
               openBanks[sBank] <= 1'b1;
            `CMD_PRECHARGE:
               if (sAddr[`ADDR_AUTOPRE])
                  openBanks <= 8'h00;
               else
                  openBanks[sBank] <= 1'b0;
            default:
               openBanks <= openBanks;
         endcase
      end
      else if (pendClose && burstState == BURST_IDLE)
         openBanks[cmdBank] <= 1'b0;
   end

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         pendClose <= 1'b0;
      else if (cmdTaken && (sCmd == `CMD_READ || sCmd == `CMD_WRITE))
         pendClose <= sAddr[`ADDR_AUTOPRE];
      else if (burstState == BURST_IDLE)
         pendClose <= 1'b0;
   end

   // ----------------------------------------------------------------------
   // Power state
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         pwrState <= PWR_ACTIVE;
      else
      begin
         case (pwrState)
            PWR_ACTIVE:
               if (clkRise && !sCe && ceLast)
               begin
                  if (!sCs && sCmd == `CMD_REFRESH && openBanks == 8'h00)
                     pwrState <= PWR_SELF_REF;
                  else if (openBanks == 8'h00)
                     pwrState <= PWR_DOWN_PRE;
                  else
                     pwrState <= PWR_DOWN_ACT;
               end
            PWR_DOWN_PRE, PWR_DOWN_ACT:
               if (clkRise && sCe)
                  pwrState <= PWR_ACTIVE;
            PWR_SELF_REF:
               if (sCe)
                  pwrState <= PWR_ACTIVE;
            default:
               pwrState <= PWR_ACTIVE;
         endcase
      end
   end

   assign buffersOn  = pwrState == PWR_ACTIVE && sCe;
   assign clkInputOn = pwrState != PWR_SELF_REF;

   // ----------------------------------------------------------------------
   // Termination
   // ----------------------------------------------------------------------
   // RTT fields: MR1 bits 9,6,2 and MR2 bits 10:9.
   wire logic rttCfg = modeReg1[9] | modeReg1[6] | modeReg1[2]
                       | modeReg2[10] | modeReg2[9];

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         termOn <= 1'b0;
      else if (pwrState == PWR_SELF_REF || !rttCfg)
         termOn <= 1'b0;
      else if (clkRise)
         termOn <= sOdt;
   end

   // ----------------------------------------------------------------------
   // Burst and write data
   // ----------------------------------------------------------------------
   logic [3:0] beatCnt;
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         burstState <= BURST_IDLE;
         burstBeats <= 4'h0;
         beatCnt    <= 4'h0;
      end
      else
      begin
         case (burstState)
            BURST_IDLE:
               if (cmdTaken && (sCmd == `CMD_READ || sCmd == `CMD_WRITE))
               begin
                  burstState <= sCmd == `CMD_WRITE ? BURST_WRITE : BURST_READ;
                  burstBeats <= beats_for(sAddr[`ADDR_CHOP]);
                  beatCnt    <= beats_for(sAddr[`ADDR_CHOP]);
               end
            BURST_WRITE:
               if (strobeEdge)
               begin
                  beatCnt <= beatCnt - 4'h1;
                  if (beatCnt == 4'h1)
                     burstState <= BURST_IDLE;
               end
            BURST_READ:
               if (clkRise)
               begin
                  beatCnt <= beatCnt - 4'h2;
                  if (beatCnt <= 4'h2)
                     burstState <= BURST_IDLE;
               end
            default:
               burstState <= BURST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         wrValid  <= 1'b0;
         wrData   <= 16'h0000;
         wrByteEn <= 2'h0;
      end
      else
      begin
         wrValid <= burstState == BURST_WRITE && strobeEdge
                    && sMask != 2'h3;
         if (burstState == BURST_WRITE && strobeEdge)
         begin
            wrData   <= sDq;
            wrByteEn <= ~sMask;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   sequence s_write_cmd;
      cmdTaken && sCmd == `CMD_WRITE;
   endsequence

   a_chip_deselect: assert property (clkRise && sCs |=> !cmdValid)
      else $error("command taken while deselected");
   a_cmd_code: assert property (cmdTaken |=> cmdCode == $past(sCmd))
      else $error("command code mismatch");
   a_prech_all: assert property (
      cmdTaken && sCmd == `CMD_PRECHARGE && sAddr[10] |=> openBanks == 8'h00)
      else $error("precharge all left banks open");
   a_chop_len: assert property (
      s_write_cmd ##0 !sAddr[12] |=> burstBeats == 4'h4)
      else $error("chopped burst length wrong");
   a_self_exit: assert property (
      pwrState == PWR_SELF_REF && sCe |=> pwrState == PWR_ACTIVE)
      else $error("self refresh exit missed");
   a_odt_ignored: assert property (!rttCfg |=> !termOn)
      else $error("termination on while disabled");
   a_buffers_off: assert property (pwrState != PWR_ACTIVE |=> !cmdValid)
      else $error("command taken in power down");
   a_mask_drop: assert property (
      burstState == BURST_WRITE && strobeEdge && sMask == 2'h3 |=> !wrValid)
      else $error("masked beat accepted");

endmodule : ddr3_pin_command_interface
`default_nettype wire

//--- bench/ddr3_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none

module ddr3_ctrl_model
(
   // System
   input  wire logic        clk_sys,
   // Pins
   output var  logic        memClk,
   output var  logic        clkEn,
   output var  logic        chipSelN,
   output var  logic        rasN,
   output var  logic        casN,
   output var  logic        weN,
   output var  logic        odt,
   output var  logic [2:0]  bankAddr,
   output var  logic [15:0] addr,
   output var  logic        dataStrobe,
   output var  logic [1:0]  dataMask,
   output var  logic [15:0] dqIn
);
   // Mode register values the bench sends with chip select low never set bit 11.
   initial
   begin
      memClk = 1'b0;
      clkEn = 1'b1;
      chipSelN = 1'b1;
      {rasN, casN, weN} = 3'h7;
      odt = 1'b0;
      bankAddr = 3'h0;
      addr = 16'h0000;
      dataStrobe = 1'b0;
      dataMask = 2'h0;
      dqIn = 16'h0000;
   end

   // The pin clock only runs inside a frame; lines let go afterwards
   // show their inverse so stale values are never mistaken for valid.
   task automatic frame(input logic s, input logic [2:0] c,
                        input logic [2:0] b, input logic [15:0] a,
                        input logic cke);
      @(negedge clk_sys);
      chipSelN = s;
      {rasN, casN, weN} = c;
      bankAddr = b;
      addr = a;
      repeat (4) @(negedge clk_sys);
      memClk = 1'b1;
      clkEn = cke;
      repeat (4) @(negedge clk_sys);
      memClk = 1'b0;
      chipSelN = 1'b1;
      {rasN, casN, weN} = ~c;
      bankAddr = ~b;
      addr = ~a;
   endtask : frame

   task automatic beat(input logic [1:0] m, input logic [15:0] d);
      @(negedge clk_sys);
      dataMask = m;
      dqIn = d;
      repeat (2) @(negedge clk_sys);
      dataStrobe = ~dataStrobe;
      repeat (2) @(negedge clk_sys);
      dataMask = ~m;
      dqIn = ~d;
   endtask : beat

   task automatic pins(input logic cke, input logic term);
      @(negedge clk_sys);
      clkEn = cke;
      odt = term;
   endtask : pins
endmodule : ddr3_ctrl_model

`default_nettype wire

//--- bench/ddr3_pin_command_interface_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ddr3_pin_consts.svh"

module ddr3_pin_command_interface_tb;
   import ddr3_pin_pkg::*;
   logic clk_sys, rstn, memClk, clkEn, chipSelN, rasN, casN, weN, odt;
   logic dataStrobe, buffersOn, clkInputOn, termOn, tdqsOn;
   logic cmdValid, autoPrecharge, wrValid;
   logic [1:0] dataMask, wrByteEn;
   logic [2:0] bankAddr, cmdBank, cmdCode, gCode, gBank;
   logic [3:0] burstBeats;
   logic [7:0] openBanks;
   logic [15:0] addr, dqIn, cmdAddr, wrData, modeReg1, modeReg2, gAddr;
   pwr_state_t pwrState;
   burst_state_t burstState;
   logic [17:0] wrQ[$];
   int badCount, nTests, nCmd, n0;

   ddr3_ctrl_model ctrl (.clk_sys(clk_sys), .memClk(memClk),
      .clkEn(clkEn), .chipSelN(chipSelN), .rasN(rasN), .casN(casN),
      .weN(weN), .odt(odt), .bankAddr(bankAddr), .addr(addr),
      .dataStrobe(dataStrobe), .dataMask(dataMask), .dqIn(dqIn));

   ddr3_pin_command_interface DUT (.clk_sys(clk_sys), .rstn(rstn),
      .memClk(memClk), .clkEn(clkEn), .chipSelN(chipSelN), .rasN(rasN),
      .casN(casN), .weN(weN), .odt(odt), .bankAddr(bankAddr),
      .addr(addr), .dataStrobe(dataStrobe), .dataMask(dataMask),
      .dqIn(dqIn), .pwrState(pwrState), .burstState(burstState),
      .buffersOn(buffersOn), .clkInputOn(clkInputOn), .termOn(termOn),
      .tdqsOn(tdqsOn), .openBanks(openBanks), .cmdBank(cmdBank),
      .cmdAddr(cmdAddr), .cmdCode(cmdCode), .cmdValid(cmdValid),
      .autoPrecharge(autoPrecharge), .burstBeats(burstBeats),
      .wrData(wrData), .wrByteEn(wrByteEn), .wrValid(wrValid),
      .modeReg1(modeReg1), .modeReg2(modeReg2));

   // ------------------------------------------------------------------
   // Clock, watchdog and monitors
   // ------------------------------------------------------------------
   initial
   begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   initial
   begin
      #200us;
      badCount++;
      final_report();
   end

   // Single-cycle pulses are caught in the cycle they stand.
   always @(posedge clk_sys)
   begin
      if (cmdValid === 1'b1)
      begin
         nCmd++;
         gCode = cmdCode;
         gBank = cmdBank;
         gAddr = cmdAddr;
      end
      if (wrValid === 1'b1)
         wrQ.push_back({wrByteEn, wrData});
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      nTests++;
      if (got !== exp)
      begin
         badCount++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic cmd(input logic [2:0] c, input logic [2:0] b,
                      input logic [15:0] a);
      ctrl.frame(1'b0, c, b, a, 1'b1);
      repeat (3) @(negedge clk_sys);
   endtask : cmd

   // A deselected frame carrying a mode register write with all ones.
   task automatic desel(input logic cke);
      ctrl.frame(1'b1, `CMD_MRS, 3'h1, 16'hffff, cke);
      repeat (3) @(negedge clk_sys);
   endtask : desel

   task automatic final_report;
      if (badCount == 0 && nTests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : final_report

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial
   begin
      rstn = 1'b0;
      repeat (16) @(negedge clk_sys);
      rstn = 1'b1;
      repeat (3) @(negedge clk_sys);
      chk(16'(cmdCode), 16'h0007);
      chk(16'(pwrState), 16'(PWR_ACTIVE));
      cmd(`CMD_MRS, 3'h1, 16'h0004);
      chk(modeReg1, 16'h0004);
      chk(16'(tdqsOn), 16'h0000);
      ctrl.pins(1'b1, 1'b1);
      n0 = nCmd;
      desel(1'b1);
      chk(16'(nCmd), 16'(n0));
      chk(modeReg1, 16'h0004);
      chk(16'(termOn), 16'h0001);
      cmd(`CMD_MRS, 3'h1, 16'h0000);
      desel(1'b1);
      chk(16'(termOn), 16'h0000);
      cmd(`CMD_MRS, 3'h2, 16'h0200);
      desel(1'b1);
      chk(modeReg2, 16'h0200);
      chk(16'(termOn), 16'h0001);
      ctrl.pins(1'b1, 1'b0);
      n0 = nCmd;
      cmd(`CMD_ACTIVATE, 3'h3, 16'h1abc);
      chk(16'(nCmd), 16'(n0 + 1));
      chk(16'(gCode), 16'(`CMD_ACTIVATE));
      chk(16'(gBank), 16'h0003);
      chk(gAddr, 16'h1abc);
      cmd(`CMD_ACTIVATE, 3'h5, 16'h0001);
      chk(16'(openBanks), 16'h0028);
      cmd(`CMD_WRITE, 3'h3, 16'h1010);
      chk(16'(burstBeats), 16'h0008);
      chk(16'(autoPrecharge), 16'h0000);
      chk(16'(burstState), 16'(BURST_WRITE));
      for (int i = 0; i < 8; i++)
         ctrl.beat(2'(i), 16'(i * 16'h1111));
      repeat (6) @(negedge clk_sys);
      chk(16'(wrQ.size()), 16'h0006);
      for (int i = 0; i < 6; i++)
      begin
         chk(16'(wrQ[i][17:16]), 16'(3 - i % 3));
         chk(wrQ[i][15:0], 16'((i % 3 + 4 * (i / 3)) * 'h1111));
      end
      chk(16'(burstState), 16'(BURST_IDLE));
      chk(16'(openBanks), 16'h0028);
      wrQ.delete();
      cmd(`CMD_WRITE, 3'h5, 16'h0420);
      chk(16'(burstBeats), 16'h0004);
      chk(16'(autoPrecharge), 16'h0001);
      for (int i = 0; i < 4; i++)
         ctrl.beat(2'h0, 16'h5a5a);
      repeat (6) @(negedge clk_sys);
      chk(16'(wrQ.size()), 16'h0004);
      chk(wrQ[3][15:0], 16'h5a5a);
      chk(16'(wrQ[3][17:16]), 16'h0003);
      chk(16'(openBanks), 16'h0008);
      cmd(`CMD_READ, 3'h3, 16'h0000);
      chk(16'(burstState), 16'(BURST_READ));
      desel(1'b1);
      desel(1'b1);
      chk(16'(burstState), 16'(BURST_IDLE));
      cmd(`CMD_ACTIVATE, 3'h1, 16'h0000);
      cmd(`CMD_PRECHARGE, 3'h3, 16'h0000);
      chk(16'(openBanks), 16'h0002);
      ctrl.pins(1'b0, 1'b0);
      desel(1'b0);
      chk(16'(pwrState), 16'(PWR_DOWN_ACT));
      chk(16'(buffersOn), 16'h0000);
      chk(16'(clkInputOn), 16'h0001);
      n0 = nCmd;
      ctrl.frame(1'b0, `CMD_ACTIVATE, 3'h6, 16'h0000, 1'b0);
      repeat (3) @(negedge clk_sys);
      chk(16'(nCmd), 16'(n0));
      ctrl.pins(1'b1, 1'b0);
      desel(1'b1);
      chk(16'(pwrState), 16'(PWR_ACTIVE));
      chk(16'(buffersOn), 16'h0001);
      cmd(`CMD_PRECHARGE, 3'h0, 16'h0400);
      chk(16'(openBanks), 16'h0000);
      ctrl.pins(1'b0, 1'b0);
      desel(1'b0);
      chk(16'(pwrState), 16'(PWR_DOWN_PRE));
      ctrl.pins(1'b1, 1'b0);
      desel(1'b1);
      ctrl.frame(1'b0, `CMD_REFRESH, 3'h0, 16'h0000, 1'b0);
      repeat (3) @(negedge clk_sys);
      chk(16'(pwrState), 16'(PWR_SELF_REF));
      chk(16'(clkInputOn), 16'h0000);
      chk(16'(buffersOn), 16'h0000);
      ctrl.pins(1'b1, 1'b0);
      repeat (6) @(negedge clk_sys);
      chk(16'(pwrState), 16'(PWR_ACTIVE));
      cmd(`CMD_ACTIVATE, 3'h2, 16'h0000);
      rstn = 1'b0;
      repeat (2) @(negedge clk_sys);
      chk(16'(openBanks), 16'h0000);
      n0 = nCmd;
      cmd(`CMD_ACTIVATE, 3'h4, 16'h0000);
      chk(16'(nCmd), 16'(n0));
      chk(16'(cmdCode), 16'h0007);
      rstn = 1'b1;
      repeat (3) @(negedge clk_sys);
      chk(16'(pwrState), 16'(PWR_ACTIVE));
      final_report();
   end
endmodule : ddr3_pin_command_interface_tb

`default_nettype wire
